// ==== logic/pmeic_pkg.sv ====
// Package: register map, field layout, reset values and timing for power and ext irq control
package pmeic_pkg;

  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PIN_CFG = 8'hE4;
  localparam logic [7:0] IDX_PRIO = 8'hF6;
  localparam logic [7:0] IDX_PWR = 8'h87;
  localparam logic [7:0] IDX_STAT = 8'h8E;
  localparam logic [7:0] IDX_AUX = 8'h8F;

  // ==========================================================================
  // Field positions
  localparam int unsigned PWR_IDLE_BIT = 0;
  localparam int unsigned PWR_STOP_BIT = 1;
  localparam int unsigned PWR_SUSP_BIT = 2;
  localparam int unsigned AUX_WDT_EN_BIT = 0;
  localparam int unsigned AUX_MCD_EN_BIT = 1;
  localparam int unsigned AUX_ZTC_EN_BIT = 2;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_PIN_CFG = 8'h01;
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [2:0] RST_PWR = 3'h0;
  localparam logic [2:0] RST_AUX = 3'h0;
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned MCD_TIMEOUT_US = 100;
  localparam int unsigned MCD_CYCLES = MCD_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned WDT_CYCLES = 16384;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic pol1;
    logic [2:0] sel1;
    logic pol0;
    logic [2:0] sel0;
  } pmeic_pin_cfg_t;

  typedef enum logic [3:0] {
    PM_RUN = 4'b0001,
    PM_IDLE = 4'b0010,
    PM_STOP = 4'b0100,
    PM_SUSP = 4'b1000
  } pmeic_state_t;

  typedef struct packed {
    logic cpu_run;
    logic periph_run;
    logic int_osc_en;
  } pmeic_clk_ctl_t;

endpackage

// ==== logic/pmeic_sync.sv ====
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/10ps
module pmeic_sync #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);

  // ==========================================================================
  // Stages
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second one
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      meta <= '0;
      o_sync <= '0;
    end else begin
      meta <= i_async;
      o_sync <= meta;
    end
  end

endmodule // pmeic_sync

// ==== logic/pmeic_ctrl.sv ====
// Power mode control, interrupt priority and external interrupt pin selection
// Operation
// - Idle entered only after the instruction that set the idle bit completes.
// - Idle keeps registers and memory intact; peripherals keep running.
// - Idle ends on enabled interrupt or reset; interrupt clears idle bit, CPU resumes.
// - Pending interrupt serviced first, then execution continues after idle instruction.
// - Reset ending idle runs normal reset sequence, fetch starts at address zero.
// - Enabled watchdog timeout during idle issues internal reset ending idle.
// - Stop bit halts internal oscillator, CPU and digital peripherals after instruction.
// - Stop exits only through reset, then fetch starts at address zero.
// - Enabled missing clock detector issues internal reset ending stop after timeout.
// - Suspend halts internal oscillator until wake; zero tempco enable set first.
// - Priority register holds one bit per source; one means high priority.
// - Polarity bits 7 and 3 select active high when one, active low when zero.
// - Three-bit pin select fields choose port-0 pins zero through seven.
// - External interrupt samples its pin independent of the crossbar, undisturbed.
`timescale 1ns/10ps
module pmeic_ctrl #(
  parameter int unsigned ADDR_W = 12,
  parameter int unsigned WDT_CYCLES = pmeic_pkg::WDT_CYCLES,
  parameter int unsigned MCD_CYCLES = pmeic_pkg::MCD_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_instr_done,
  input wire logic [7:0] i_irq_req,
  input wire logic [7:0] i_irq_enable,
  input wire logic [7:0] i_port0_pins,
  output logic o_ext_irq0,
  output logic o_ext_irq1,
  output logic [7:0] o_irq_prio,
  output logic o_cpu_run,
  output logic o_periph_run,
  output logic o_int_osc_en,
  output logic o_wake_irq,
  output logic o_int_reset,
  output logic [15:0] o_boot_addr
);

  // ==========================================================================
  // Declarations
  pmeic_pkg::pmeic_state_t state, next_state;
  pmeic_pkg::pmeic_pin_cfg_t pin_cfg;
  pmeic_pkg::pmeic_clk_ctl_t clk_ctl;
  logic [2:0] pwr, aux;
  logic [7:0] port0_sync;
  logic [31:0] wdt_cnt, mcd_cnt;
  logic setup_phase, access_wr, mapped;
  logic irq_hit, ext_hit, wdt_fire, mcd_fire, reset_fire;
  logic hit_pin_cfg, hit_prio, hit_pwr, hit_stat, hit_aux;

  // ==========================================================================
  // Address decode
  function automatic logic addr_is(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    addr_is = (addr == ADDR_W'({idx, 2'b00}));
  endfunction

  always_comb begin
    hit_pin_cfg = 1'b0;
    hit_prio = 1'b0;
    hit_pwr = 1'b0;
    hit_stat = 1'b0;
    hit_aux = 1'b0;
    if (addr_is(i_paddr, pmeic_pkg::IDX_PIN_CFG)) begin
      hit_pin_cfg = 1'b1;
    end else if (addr_is(i_paddr, pmeic_pkg::IDX_PRIO)) begin
      hit_prio = 1'b1;
    end else if (addr_is(i_paddr, pmeic_pkg::IDX_PWR)) begin
      hit_pwr = 1'b1;
    end else if (addr_is(i_paddr, pmeic_pkg::IDX_STAT)) begin
      hit_stat = 1'b1;
    end else if (addr_is(i_paddr, pmeic_pkg::IDX_AUX)) begin
      hit_aux = 1'b1;
    end
  end

  assign mapped = hit_pin_cfg | hit_prio | hit_pwr | hit_stat | hit_aux;
  assign setup_phase = i_psel & ~i_penable;
  assign access_wr = i_psel & i_penable & i_pwrite & mapped;

  // Zero wait states: read data is captured in the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  // ==========================================================================
  // Read data
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup_phase && !i_pwrite) begin
      if (hit_pin_cfg) begin
        o_prdata <= {24'h00_0000, pin_cfg};
      end else if (hit_prio) begin
        o_prdata <= {24'h00_0000, o_irq_prio};
      end else if (hit_pwr) begin
        o_prdata <= {29'h0000_0000, pwr};
      end else if (hit_stat) begin
        o_prdata <= {26'h000_0000, o_ext_irq1, o_ext_irq0, state};
      end else if (hit_aux) begin
        o_prdata <= {29'h0000_0000, aux};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq_prio <= pmeic_pkg::RST_PRIO;
    end else if (access_wr && hit_prio) begin
      o_irq_prio <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      pin_cfg <= pmeic_pkg::RST_PIN_CFG;
    end else if (access_wr && hit_pin_cfg) begin
      pin_cfg <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || reset_fire) begin
      aux <= pmeic_pkg::RST_AUX;
    end else if (access_wr && hit_aux) begin
      aux <= i_pwdata[2:0];
    end
  end

  // Mode bits: idle and suspend cleared by wake, all by internal reset; software writes them only in run
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || reset_fire) begin
      pwr <= pmeic_pkg::RST_PWR;
    end else if ((state == pmeic_pkg::PM_IDLE) && irq_hit) begin
      pwr[pmeic_pkg::PWR_IDLE_BIT] <= 1'b0;
    end else if ((state == pmeic_pkg::PM_SUSP) && (irq_hit || ext_hit)) begin
      pwr[pmeic_pkg::PWR_SUSP_BIT] <= 1'b0;
    end else if (access_wr && hit_pwr && (state == pmeic_pkg::PM_RUN)) begin
      pwr[pmeic_pkg::PWR_IDLE_BIT] <= i_pwdata[pmeic_pkg::PWR_IDLE_BIT];
      pwr[pmeic_pkg::PWR_STOP_BIT] <= i_pwdata[pmeic_pkg::PWR_STOP_BIT];
      // Suspend without the zero tempco enable would wake with a drifted
      // reference, so the request is dropped
      pwr[pmeic_pkg::PWR_SUSP_BIT] <= i_pwdata[pmeic_pkg::PWR_SUSP_BIT]
        & aux[pmeic_pkg::AUX_ZTC_EN_BIT];
    end
  end

  // ==========================================================================
  // External interrupt pins
  // Pins are only observed, never driven, so crossbar routing is untouched
  pmeic_sync #(
    .WIDTH(8)
  ) u_port0_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_port0_pins),
    .o_sync(port0_sync)
  );

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ext_irq0 <= 1'b0;
      o_ext_irq1 <= 1'b0;
    end else begin
      o_ext_irq0 <= port0_sync[pin_cfg.sel0] ^ ~pin_cfg.pol0;
      o_ext_irq1 <= port0_sync[pin_cfg.sel1] ^ ~pin_cfg.pol1;
    end
  end

  assign irq_hit = |(i_irq_req & i_irq_enable);
  assign ext_hit = o_ext_irq0 | o_ext_irq1;

  // ==========================================================================
  // Timeout counters
  // Watchdog only runs its idle timeout here; the core services it while awake
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || (state != pmeic_pkg::PM_IDLE) || !aux[pmeic_pkg::AUX_WDT_EN_BIT]) begin
      wdt_cnt <= 32'h0000_0000;
    end else if (!wdt_fire) begin
      wdt_cnt <= wdt_cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n || (state != pmeic_pkg::PM_STOP) || !aux[pmeic_pkg::AUX_MCD_EN_BIT]) begin
      mcd_cnt <= 32'h0000_0000;
    end else if (!mcd_fire) begin
      mcd_cnt <= mcd_cnt + 32'h0000_0001;
    end
  end

  assign wdt_fire = (state == pmeic_pkg::PM_IDLE) && aux[pmeic_pkg::AUX_WDT_EN_BIT]
    && (wdt_cnt == 32'(WDT_CYCLES - 1));
  assign mcd_fire = (state == pmeic_pkg::PM_STOP) && aux[pmeic_pkg::AUX_MCD_EN_BIT]
    && (mcd_cnt == 32'(MCD_CYCLES - 1));
  assign reset_fire = wdt_fire | mcd_fire;

  // ==========================================================================
  // Power mode state machine
  always_comb begin
    next_state = state;
    case (state)
      pmeic_pkg::PM_RUN: begin
        // Entry waits for the setting instruction to complete
        if (i_instr_done && pwr[pmeic_pkg::PWR_STOP_BIT]) begin
          next_state = pmeic_pkg::PM_STOP;
        end else if (i_instr_done && pwr[pmeic_pkg::PWR_IDLE_BIT]) begin
          next_state = pmeic_pkg::PM_IDLE;
        end else if (i_instr_done && pwr[pmeic_pkg::PWR_SUSP_BIT]) begin
          next_state = pmeic_pkg::PM_SUSP;
        end
      end
      pmeic_pkg::PM_IDLE: begin
        if (reset_fire || irq_hit) begin
          next_state = pmeic_pkg::PM_RUN;
        end
      end
      pmeic_pkg::PM_STOP: begin
        if (reset_fire) begin
          next_state = pmeic_pkg::PM_RUN;
        end
      end
      pmeic_pkg::PM_SUSP: begin
        if (irq_hit || ext_hit) begin
          next_state = pmeic_pkg::PM_RUN;
        end
      end
      default: begin
        next_state = pmeic_pkg::PM_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= pmeic_pkg::PM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Clock gating outputs
  always_comb begin
    clk_ctl = '{cpu_run: 1'b1, periph_run: 1'b1, int_osc_en: 1'b1};
    case (next_state)
      pmeic_pkg::PM_IDLE: begin
        clk_ctl.cpu_run = 1'b0;
      end
      pmeic_pkg::PM_STOP: begin
        clk_ctl = '{cpu_run: 1'b0, periph_run: 1'b0, int_osc_en: 1'b0};
      end
      pmeic_pkg::PM_SUSP: begin
        clk_ctl = '{cpu_run: 1'b0, periph_run: 1'b0, int_osc_en: 1'b0};
      end
      default: begin
        clk_ctl = '{cpu_run: 1'b1, periph_run: 1'b1, int_osc_en: 1'b1};
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_cpu_run <= 1'b1;
      o_periph_run <= 1'b1;
      o_int_osc_en <= 1'b1;
    end else begin
      o_cpu_run <= clk_ctl.cpu_run;
      o_periph_run <= clk_ctl.periph_run;
      o_int_osc_en <= clk_ctl.int_osc_en;
    end
  end

  // ==========================================================================
  // Wake and reset events
  // The core keeps its PC, so after the handler returns it resumes past the halt
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_wake_irq <= 1'b0;
    end else begin
      o_wake_irq <= (state == pmeic_pkg::PM_IDLE) && irq_hit && !reset_fire;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_int_reset <= 1'b0;
      o_boot_addr <= pmeic_pkg::RESET_VECTOR;
    end else begin
      o_int_reset <= reset_fire;
      o_boot_addr <= pmeic_pkg::RESET_VECTOR;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Clock outputs follow the next state, so they change with the state itself
  property p_idle_entry;
    (state == pmeic_pkg::PM_RUN) && pwr[pmeic_pkg::PWR_IDLE_BIT]
      && !pwr[pmeic_pkg::PWR_STOP_BIT] && i_instr_done
      |=> (state == pmeic_pkg::PM_IDLE) && !o_cpu_run;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
  property p_no_early_halt;
    (state == pmeic_pkg::PM_RUN) && !i_instr_done |=> (state == pmeic_pkg::PM_RUN);
  endproperty
  a_no_early_halt: assert property (p_no_early_halt) else $error("halt before done");
  property p_idle_wake;
    (state == pmeic_pkg::PM_IDLE) && irq_hit && !reset_fire
      |=> (state == pmeic_pkg::PM_RUN) && !pwr[pmeic_pkg::PWR_IDLE_BIT]
      && o_wake_irq && o_cpu_run;
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");
  property p_idle_periph;
    (state == pmeic_pkg::PM_IDLE) ##1 (state == pmeic_pkg::PM_IDLE) |-> o_periph_run;
  endproperty
  a_idle_periph: assert property (p_idle_periph) else $error("periph stopped in idle");
  property p_wdt_reset;
    o_int_reset && $past(state) == pmeic_pkg::PM_IDLE
      |-> $past(wdt_cnt) == 32'(WDT_CYCLES - 1) && state == pmeic_pkg::PM_RUN
      && o_boot_addr == 16'h0000;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset wrong");
  property p_stop_hold;
    (state == pmeic_pkg::PM_STOP) && !reset_fire |=> (state == pmeic_pkg::PM_STOP);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");
  property p_stop_clocks;
    (state == pmeic_pkg::PM_STOP) |-> !o_cpu_run && !o_periph_run && !o_int_osc_en;
  endproperty
  a_stop_clocks: assert property (p_stop_clocks) else $error("clock runs in stop");
  property p_mcd_reset;
    mcd_fire |=> o_int_reset && (state == pmeic_pkg::PM_RUN) && (pwr == 3'h0);
  endproperty
  a_mcd_reset: assert property (p_mcd_reset) else $error("mcd reset missing");
  property p_susp_ztc;
    $rose(pwr[pmeic_pkg::PWR_SUSP_BIT]) |-> aux[pmeic_pkg::AUX_ZTC_EN_BIT];
  endproperty
  a_susp_ztc: assert property (p_susp_ztc) else $error("suspend without ztc");
  property p_prio_write;
    access_wr && hit_prio |=> o_irq_prio == $past(i_pwdata[7:0]);
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority not stored");
  // The output flop is still in reset at the releasing edge, so start after it
  property p_ext_map;
    i_rst_n |=> o_ext_irq0 == ($past(port0_sync[pin_cfg.sel0]) ^ ~$past(pin_cfg.pol0));
  endproperty
  a_ext_map: assert property (p_ext_map) else $error("ext irq0 mapping wrong");

  c_idle_wake: cover property ((state == pmeic_pkg::PM_IDLE) ##1 o_wake_irq);
  c_stop_mcd: cover property ((state == pmeic_pkg::PM_STOP) ##1 o_int_reset);
  c_susp_wake: cover property ((state == pmeic_pkg::PM_SUSP) ##1 (state == pmeic_pkg::PM_RUN));

endmodule // pmeic_ctrl

// ==== verification/pmeic_core_model.sv ====
// Behavioural processor core and peripheral interrupt sources for the power control block
`timescale 1ns/10ps
module pmeic_core_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_exec,
  input wire logic i_raise,
  input wire logic [7:0] i_vec,
  input wire logic [7:0] i_en,
  input wire logic i_cpu_run,
  input wire logic i_wake_irq,
  input wire logic i_int_reset,
  input wire logic [15:0] i_boot_addr,
  output logic o_instr_done,
  output logic [7:0] o_irq_req,
  output logic [7:0] o_irq_enable,
  output logic [15:0] o_pc,
  output logic [7:0] o_served
);
  // ==========================================================================
  // Retirement: a halted core cannot complete an instruction
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_instr_done <= 1'b0;
    end else begin
      o_instr_done <= i_exec & i_cpu_run;
    end
  end

  // ==========================================================================
  // Fetch restarts at the boot address after any reset
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_int_reset) begin
      o_pc <= i_boot_addr;
    end else if (o_instr_done) begin
      o_pc <= o_pc + 16'h0001;
    end
  end

  // ==========================================================================
  // A request stays up until the core services it or an internal reset drops it; the return resumes at o_pc
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_irq_req <= 8'h00;
      o_served <= 8'h00;
    end else if (i_int_reset) begin
      o_irq_req <= 8'h00;
    end else if (i_wake_irq) begin
      o_irq_req <= 8'h00;
      o_served <= o_served + 8'h01;
    end else if (i_raise) begin
      o_irq_req <= i_vec;
    end
  end

  assign o_irq_enable = i_en;
endmodule // pmeic_core_model

// ==== verification/tb.sv ====
// Self-checking testbench for the power mode and external interrupt control block
`timescale 1ns/10ps
module tb;
  localparam int WDT = 16;
  localparam int MISSING_CLOCK_DETECTOR = 20;
  localparam logic [11:0] A_CFG = {2'b00, pmeic_pkg::IDX_PIN_CFG, 2'b00};
  localparam logic [11:0] A_PRIO = {2'b00, pmeic_pkg::IDX_PRIO, 2'b00};
  localparam logic [11:0] A_PWR = {2'b00, pmeic_pkg::IDX_PWR, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, pmeic_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_AUX = {2'b00, pmeic_pkg::IDX_AUX, 2'b00};
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} pmeic_row_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, instr_done, ext0, ext1;
  logic cpu_run, periph_run, osc_en, wake, int_rst, exec, raise;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] irq_req, irq_en, pins, prio, vec, en, served, pv;
  logic [15:0] boot, pc, pc0;
  logic er;
  int err_count = 0;
  int cmp_count = 0;
  int n;
  pmeic_row_t rows [6];

  always #2 clk = ~clk;

  pmeic_ctrl #(.WDT_CYCLES(WDT), .MCD_CYCLES(MISSING_CLOCK_DETECTOR)) u_pmeic_ctrl (.i_clk(clk), .i_rst_n(rst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_instr_done(instr_done),
    .i_irq_req(irq_req), .i_irq_enable(irq_en), .i_port0_pins(pins), .o_ext_irq0(ext0),
    .o_ext_irq1(ext1), .o_irq_prio(prio), .o_cpu_run(cpu_run), .o_periph_run(periph_run),
    .o_int_osc_en(osc_en), .o_wake_irq(wake), .o_int_reset(int_rst), .o_boot_addr(boot));
  pmeic_core_model u_pmeic_core_model (.i_clk(clk), .i_rst_n(rst_n), .i_exec(exec),
    .i_raise(raise), .i_vec(vec), .i_en(en), .i_cpu_run(cpu_run), .i_wake_irq(wake),
    .i_int_reset(int_rst), .i_boot_addr(boot), .o_instr_done(instr_done),
    .o_irq_req(irq_req), .o_irq_enable(irq_en), .o_pc(pc), .o_served(served));

  // ==========================================================================
  // Checking and closing
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk_d(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic chk_b(input string nm, input logic e, input logic g);
    chk_d(nm, {31'h0, e}, {31'h0, g});
  endtask

  // ==========================================================================
  // Bus and core stimulus; every task starts and ends right after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    chk_b("bus ready", 1'b1, pready);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so that a following transfer never reassigns psel in this step
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdv(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic exec_instr;
    exec <= 1'b1;
    cyc(1);
    exec <= 1'b0;
    cyc(2);
  endtask
  task automatic raise_irq(input logic [7:0] v);
    raise <= 1'b1;
    vec <= v;
    cyc(1);
    raise <= 1'b0;
  endtask
  // Bounded wait for a one-cycle pulse; k reaches 100 if it never comes
  task automatic wait_for(input bit ir, output int k);
    k = 0;
    while ((ir ? int_rst : wake) !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
  endtask

  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    finish_test();
  end

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    {psel, penable, pwrite, exec, raise} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    {vec, en} = 16'h0000;
    pins = 8'hFF;
    rows = '{'{A_CFG, 32'h000000A7, 32'h000000A7, 1'b0},
      '{A_PRIO, 32'hFFFFFF5A, 32'h0000005A, 1'b0}, '{A_PRIO, 32'h000000A5, 32'h000000A5, 1'b0},
      '{12'h004, 32'h000000FF, 32'h0, 1'b1}, '{A_AUX, 32'h00000004, 32'h00000004, 1'b0},
      '{A_AUX, 32'h0, 32'h0, 1'b0}};
    cyc(5);
    rst_n <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk_b("write error flag", rows[i].e, er);
      rdv(rows[i].a);
      chk_d("read data", rows[i].q, rd);
      if (rows[i].a == A_PRIO) chk_d("prio out", rows[i].q, {24'h0, prio});
    end
    // Every pin code under both polarities, the two inputs watching mirrored pins
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 2; p++) begin
        pv = 8'h69 ^ 8'(c);
        wr(A_CFG, {24'h0, ~p[0], 3'(7 - c), p[0], 3'(c)});
        pins <= pv;
        cyc(4);
        chk_b("ext irq 0", pv[c] ^ ~p[0], ext0);
        chk_b("ext irq 1", pv[7 - c] ^ p[0], ext1);
      end
    end
    // Both external inputs inactive so they cannot wake suspend early
    pins <= 8'hFF;
    wr(A_CFG, 32'h0);
    // Idle: a disabled request must not wake, an enabled one must
    wr(A_PRIO, 32'h3C);
    raise_irq(8'h04);
    wr(A_PWR, 32'h1);
    pc0 = pc;
    exec_instr();
    chk_b("cpu idle", 1'b0, cpu_run);
    chk_b("periph idle", 1'b1, periph_run);
    chk_b("osc idle", 1'b1, osc_en);
    cyc(5);
    chk_b("cpu held", 1'b0, cpu_run);
    rdv(A_STAT);
    chk_d("state idle", 32'h2, {28'h0, rd[3:0]});
    rdv(A_PRIO);
    chk_d("prio kept", 32'h3C, rd);
    en <= 8'h04;
    wait_for(1'b0, n);
    chk_b("wake pulse", 1'b1, wake);
    cyc(1);
    chk_b("wake one cycle", 1'b0, wake);
    chk_b("cpu resumed", 1'b1, cpu_run);
    rdv(A_PWR);
    chk_d("idle bit cleared", 32'h0, rd);
    chk_d("serviced", 32'h1, {24'h0, served});
    chk_d("resume pc", {16'h0, pc0 + 16'h1}, {16'h0, pc});
    en <= 8'h00;
    // Watchdog ends idle by internal reset
    wr(A_AUX, 32'h1);
    wr(A_PWR, 32'h1);
    exec_instr();
    wait_for(1'b1, n);
    chk_b("watchdog span", 1'b1, n >= WDT - 4 && n <= WDT + 2);
    cyc(2);
    chk_b("cpu after wdt", 1'b1, cpu_run);
    chk_d("fetch at zero", 32'h0, {16'h0, pc});
    rdv(A_AUX);
    chk_d("aux cleared", 32'h0, rd);
    // Stop: an enabled interrupt must not end it, only a reset
    wr(A_PWR, 32'h2);
    exec_instr();
    chk_b("cpu stop", 1'b0, cpu_run);
    chk_b("periph stop", 1'b0, periph_run);
    chk_b("osc stop", 1'b0, osc_en);
    raise_irq(8'h01);
    en <= 8'h01;
    wait_for(1'b0, n);
    chk_b("stop kept", 1'b1, n >= 100 && osc_en === 1'b0);
    rst_n <= 1'b0;
    cyc(2);
    rst_n <= 1'b1;
    en <= 8'h00;
    cyc(2);
    chk_b("cpu after reset", 1'b1, cpu_run);
    chk_d("boot address", 32'h0, {16'h0, boot});
    // Missing clock detector ends stop
    wr(A_AUX, 32'h2);
    wr(A_PWR, 32'h2);
    exec_instr();
    wait_for(1'b1, n);
    chk_b("mcd span", 1'b1, n >= MISSING_CLOCK_DETECTOR - 4 && n <= MISSING_CLOCK_DETECTOR + 2);
    cyc(2);
    chk_b("osc after mcd", 1'b1, osc_en);
    // Suspend is dropped until the tempco enable is set first
    wr(A_PWR, 32'h4);
    exec_instr();
    chk_b("suspend refused", 1'b1, osc_en);
    wr(A_AUX, 32'h4);
    wr(A_PWR, 32'h4);
    exec_instr();
    chk_b("osc suspended", 1'b0, osc_en);
    rdv(A_STAT);
    chk_d("state suspend", 32'h8, {28'h0, rd[3:0]});
    raise_irq(8'h10);
    en <= 8'h10;
    n = 0;
    while (osc_en !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    chk_b("suspend woken", 1'b1, osc_en);
    en <= 8'h00;
    // Third reset mid-run restores the documented reset values
    pins <= 8'h00;
    rst_n <= 1'b0;
    cyc(5);
    rst_n <= 1'b1;
    cyc(4);
    rdv(A_CFG);
    chk_d("cfg reset", {24'h0, pmeic_pkg::RST_PIN_CFG}, rd);
    rdv(A_PRIO);
    chk_d("prio reset", 32'h0, rd);
    rdv(A_STAT);
    chk_d("status reset", 32'h31, rd);
    finish_test();
  end
endmodule // tb
